// *** core/chi_pkg.sv ***
// shared constants of the charger two-wire register port
package chi_pkg;
  localparam logic [6:0] CHI_SLAVE_ADDR   = 7'h6b;
  localparam logic [5:0] CHI_FIRST_REG    = 6'h00;
  localparam logic [5:0] CHI_LAST_REG     = 6'h25;
  localparam int         CHI_NUM_REGS     = 38;
  localparam logic [7:0] CHI_FILL_BYTE    = 8'hff;
  // read-only status and result ranges, flag range inside the first
  localparam logic [5:0] CHI_RO0_LO       = 6'h0a;
  localparam logic [5:0] CHI_RO0_HI       = 6'h11;
  localparam logic [5:0] CHI_FLAG_LO      = 6'h0f;
  localparam logic [5:0] CHI_FLAG_HI      = 6'h11;
  localparam logic [5:0] CHI_RO1_LO       = 6'h17;
  localparam logic [5:0] CHI_RO1_HI       = 6'h24;
  localparam logic [7:0] CHI_RST_FIRST_REGISTER = 8'ha0;
  localparam logic [7:0] CHI_RST_CHG_LIMIT      = 8'h54;
  localparam logic [5:0] CHI_CHG_LIMIT_REG      = 6'h01;
  // host timing at the 20 MHz master clock
  localparam int CHI_CLK_NS      = 50;
  localparam int CHI_STD_KBPS    = 100;
  localparam int CHI_FAST_KBPS   = 400;
  localparam int CHI_STD_BIT_NS  = 1000000 / CHI_STD_KBPS;
  localparam int CHI_FAST_BIT_NS = 1000000 / CHI_FAST_KBPS;
  // quarter bit is a least time, so round up
  localparam int CHI_STD_QTR  =
    (CHI_STD_BIT_NS + 4 * CHI_CLK_NS - 1) / (4 * CHI_CLK_NS);
  localparam int CHI_FAST_QTR =
    (CHI_FAST_BIT_NS + 4 * CHI_CLK_NS - 1) / (4 * CHI_CLK_NS);
  localparam int CHI_STRETCH_CYC = 4;
endpackage

// *** core/chi_if.sv ***
// open-drain two-wire link joining host end and device end
`timescale 1ns/1ps
`default_nettype none
interface chi_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_scl_o;
  logic dev_scl_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;
  // pull-up: a line is low only while some end drives its low output
  assign scl = (host_scl_oe_n | host_scl_o) & (dev_scl_oe_n | dev_scl_o);
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
  modport host (input scl, sda,
                output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n);
  modport dev  (input scl, sda,
                output dev_scl_o, dev_scl_oe_n, dev_sda_o, dev_sda_oe_n);
endinterface
`default_nettype wire

// *** core/chi_dev.sv ***
// device end: two-wire slave with the byte register file
`timescale 1ns/1ps
`default_nettype none
module chi_dev
  import chi_pkg::*;
#(
  parameter int STRETCH_CYC = CHI_STRETCH_CYC
) (
  input  wire logic       link_clk_i,
  input  wire logic       rst_i,
  chi_if.dev              bus,
  input  wire logic       hw_wr_i,
  input  wire logic [5:0] hw_addr_i,
  input  wire logic [7:0] hw_data_i,
  output logic            host_wr_o,
  output logic [5:0]      host_wr_addr_o,
  output logic [7:0]      host_wr_data_o,
  output logic            busy_o
);

  // stretch counter is four bits wide
  if (STRETCH_CYC < 0 || STRETCH_CYC > 15) begin : g_bad_stretch
    $error("chi_dev: STRETCH_CYC must lie in 0..15");
  end

  typedef enum logic [2:0] {
    CHI_D_IDLE = 3'b000,
    CHI_D_ADDR = 3'b001,
    CHI_D_ACK  = 3'b011,
    CHI_D_RX   = 3'b010,
    CHI_D_TX   = 3'b110,
    CHI_D_MACK = 3'b111
  } chi_dev_e;

  typedef struct packed {
    logic                        scl_s1;
    logic                        scl_s2;
    logic                        scl_p;
    logic                        sda_s1;
    logic                        sda_s2;
    logic                        sda_p;
    chi_dev_e                    st;
    logic [3:0]                  bitcnt;
    logic [7:0]                  shift;
    logic [5:0]                  ptr;
    logic                        rw;
    logic                        regph;
    logic                        mack;
    logic                        busy;
    logic                        sda_oe_n;
    logic                        scl_oe_n;
    logic [3:0]                  str;
    logic                        wr_v;
    logic [5:0]                  wr_a;
    logic [7:0]                  wr_d;
    logic [CHI_NUM_REGS-1:0][7:0] regs;
  } chi_dev_s;

  chi_dev_s s_reg;
  chi_dev_s s_next;

  function automatic logic chi_is_flag(input logic [5:0] a);
    return (a >= CHI_FLAG_LO) && (a <= CHI_FLAG_HI);
  endfunction

  function automatic logic chi_is_ro(input logic [5:0] a);
    return ((a >= CHI_RO0_LO) && (a <= CHI_RO0_HI)) ||
           ((a >= CHI_RO1_LO) && (a <= CHI_RO1_HI));
  endfunction

  function automatic chi_dev_s chi_rst_val();
    chi_dev_s r;
    r = '0;
    r.scl_s1 = 1'b1;
    r.scl_s2 = 1'b1;
    r.scl_p = 1'b1;
    r.sda_s1 = 1'b1;
    r.sda_s2 = 1'b1;
    r.sda_p = 1'b1;
    r.st = CHI_D_IDLE;
    r.sda_oe_n = 1'b1;
    r.scl_oe_n = 1'b1;
    r.regs[CHI_FIRST_REG] = CHI_RST_FIRST_REGISTER;
    r.regs[CHI_CHG_LIMIT_REG] = CHI_RST_CHG_LIMIT;
    return r;
  endfunction

  always_comb begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic load;
    logic [7:0] rd;
    rise = 1'b0;
    fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    load = 1'b0;
    rd = CHI_FILL_BYTE;
    s_next = s_reg;
    s_next.wr_v = 1'b0;
    // raw pins go through two flops before any logic reads them
    s_next.scl_s1 = bus.scl;
    s_next.scl_s2 = s_reg.scl_s1;
    s_next.scl_p = s_reg.scl_s2;
    s_next.sda_s1 = bus.sda;
    s_next.sda_s2 = s_reg.sda_s1;
    s_next.sda_p = s_reg.sda_s2;
    rise = s_reg.scl_s2 & ~s_reg.scl_p;
    fall = ~s_reg.scl_s2 & s_reg.scl_p;
    start = s_reg.scl_s2 & s_reg.scl_p & s_reg.sda_p & ~s_reg.sda_s2;
    stop = s_reg.scl_s2 & s_reg.scl_p & ~s_reg.sda_p & s_reg.sda_s2;

    if (s_reg.str != 4'h0) begin
      s_next.str = s_reg.str - 4'h1;
      s_next.scl_oe_n = (s_reg.str == 4'h1);
    end

    if (start) begin
      s_next.st = CHI_D_ADDR;
      s_next.busy = 1'b1;
      s_next.bitcnt = 4'h0;
      s_next.sda_oe_n = 1'b1;
    end else if (stop) begin
      s_next.st = CHI_D_IDLE;
      s_next.busy = 1'b0;
      s_next.sda_oe_n = 1'b1;
    end else begin
      case (s_reg.st)
        CHI_D_ADDR, CHI_D_RX: begin
          if (rise) begin
            s_next.shift = {s_reg.shift[6:0], s_reg.sda_s2};
            s_next.bitcnt = s_reg.bitcnt + 4'h1;
          end else if (fall && s_reg.bitcnt == 4'h8) begin
            s_next.st = CHI_D_IDLE;
            if (s_reg.st == CHI_D_ADDR) begin
              if (s_reg.shift[7:1] == CHI_SLAVE_ADDR) begin
                s_next.st = CHI_D_ACK;
                s_next.rw = s_reg.shift[0];
                s_next.regph = ~s_reg.shift[0];
              end
            end else if (s_reg.regph) begin
              if (s_reg.shift <= {2'b00, CHI_LAST_REG}) begin
                s_next.st = CHI_D_ACK;
                s_next.ptr = s_reg.shift[5:0];
                s_next.regph = 1'b0;
              end
            end else if (s_reg.ptr <= CHI_LAST_REG) begin
              s_next.st = CHI_D_ACK;
              if (!chi_is_ro(s_reg.ptr)) begin
                s_next.regs[s_reg.ptr] = s_reg.shift;
                s_next.wr_v = 1'b1;
                s_next.wr_a = s_reg.ptr;
                s_next.wr_d = s_reg.shift;
              end
              s_next.ptr = s_reg.ptr + 6'h1;
            end
            // clock is low here, so the ack level may be set now
            s_next.sda_oe_n = (s_next.st != CHI_D_ACK);
          end
        end
        CHI_D_ACK: begin
          if (fall) begin
            s_next.sda_oe_n = 1'b1;
            s_next.bitcnt = 4'h0;
            s_next.str = 4'(STRETCH_CYC);
            s_next.scl_oe_n = (STRETCH_CYC == 0);
            if (s_reg.rw) begin
              load = 1'b1;
            end else begin
              s_next.st = CHI_D_RX;
            end
          end
        end
        CHI_D_TX: begin
          if (rise) begin
            s_next.bitcnt = s_reg.bitcnt + 4'h1;
          end else if (fall) begin
            if (s_reg.bitcnt == 4'h8) begin
              s_next.sda_oe_n = 1'b1;
              s_next.st = CHI_D_MACK;
            end else begin
              s_next.shift = {s_reg.shift[6:0], 1'b0};
              s_next.sda_oe_n = s_reg.shift[6];
            end
          end
        end
        CHI_D_MACK: begin
          if (rise) begin
            s_next.mack = ~s_reg.sda_s2;
          end else if (fall) begin
            if (s_reg.mack) begin
              load = 1'b1;
            end else begin
              s_next.st = CHI_D_IDLE;
            end
          end
        end
        default: begin
          s_next.sda_oe_n = 1'b1;
        end
      endcase
    end

    if (load) begin
      if (s_reg.ptr <= CHI_LAST_REG) begin
        rd = s_reg.regs[s_reg.ptr];
        if (chi_is_flag(s_reg.ptr)) begin
          s_next.regs[s_reg.ptr] = 8'h00;
        end
        s_next.ptr = s_reg.ptr + 6'h1;
      end else begin
        rd = CHI_FILL_BYTE;
      end
      s_next.st = CHI_D_TX;
      s_next.bitcnt = 4'h0;
      s_next.shift = rd;
      s_next.sda_oe_n = rd[7];
    end

    // hardware status update comes last so a new flag beats the clear
    if (hw_wr_i && hw_addr_i <= CHI_LAST_REG && chi_is_ro(hw_addr_i)) begin
      if (chi_is_flag(hw_addr_i)) begin
        s_next.regs[hw_addr_i] = s_next.regs[hw_addr_i] | hw_data_i;
      end else begin
        s_next.regs[hw_addr_i] = hw_data_i;
      end
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (rst_i) begin
      s_reg <= chi_rst_val();
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.dev_scl_o = 1'b0;
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_scl_oe_n = s_reg.scl_oe_n;
  assign bus.dev_sda_oe_n = s_reg.sda_oe_n;
  assign host_wr_o = s_reg.wr_v;
  assign host_wr_addr_o = s_reg.wr_a;
  assign host_wr_data_o = s_reg.wr_d;
  assign busy_o = s_reg.busy;

endmodule
`default_nettype wire

// *** core/chi_host.sv ***
// host end: two-wire master issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none
module chi_host
  import chi_pkg::*;
#(
  parameter int FAST = 1
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  chi_if.host             bus,
  input  wire logic       cmd_valid_i,
  output logic            cmd_ready_o,
  input  wire logic       cmd_read_i,
  input  wire logic [7:0] cmd_reg_i,
  input  wire logic [7:0] cmd_data_i,
  input  wire logic [5:0] cmd_len_i,
  output logic            rd_valid_o,
  output logic [7:0]      rd_data_o,
  output logic            done_o,
  output logic            nack_o
);

  localparam int QTR = (FAST != 0) ? CHI_FAST_QTR : CHI_STD_QTR;

  // quarter counter is eight bits wide
  if (QTR < 1 || QTR > 255) begin : g_bad_qtr
    $error("chi_host: quarter bit count out of range");
  end

  typedef enum logic [1:0] {
    CHI_H_IDLE  = 2'b00,
    CHI_H_START = 2'b01,
    CHI_H_BIT   = 2'b11,
    CHI_H_STOP  = 2'b10
  } chi_host_e;

  typedef struct packed {
    logic       scl_s1;
    logic       scl_s2;
    logic       sda_s1;
    logic       sda_s2;
    chi_host_e  st;
    logic [1:0] q;
    logic [7:0] qc;
    logic [3:0] bitn;
    logic [2:0] stp;
    logic [7:0] sh;
    logic       rd;
    logic [7:0] reg_a;
    logic [7:0] wdat;
    logic [5:0] cnt;
    logic       scl_oe_n;
    logic       sda_oe_n;
    logic       done;
    logic       nack;
    logic       rv;
    logic [7:0] rdata;
  } chi_host_s;

  chi_host_s s_reg;
  chi_host_s s_next;

  always_comb begin
    logic adv;
    logic want;
    adv = 1'b0;
    want = 1'b1;
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.rv = 1'b0;
    s_next.scl_s1 = bus.scl;
    s_next.scl_s2 = s_reg.scl_s1;
    s_next.sda_s1 = bus.sda;
    s_next.sda_s2 = s_reg.sda_s1;
    // a held clock line stops the high quarter from running out
    adv = (s_reg.qc == 8'h00) && !(s_reg.q == 2'd2 && !s_reg.scl_s2);
    if (s_reg.st == CHI_H_IDLE) begin
      if (cmd_valid_i) begin
        s_next.st = CHI_H_START;
        // from idle the clock is already high: no stray pulse before start
        s_next.q = 2'd2;
        s_next.qc = 8'(QTR - 1);
        s_next.stp = 3'd0;
        s_next.rd = cmd_read_i;
        s_next.reg_a = cmd_reg_i;
        s_next.wdat = cmd_data_i;
        s_next.cnt = (cmd_len_i == 6'h00) ? 6'h01 : cmd_len_i;
        s_next.nack = 1'b0;
      end
    end else if (s_reg.qc != 8'h00) begin
      s_next.qc = s_reg.qc - 8'h01;
    end else if (adv) begin
      s_next.qc = 8'(QTR - 1);
      s_next.q = s_reg.q + 2'd1;
      if (s_reg.q == 2'd3) begin
        case (s_reg.st)
          CHI_H_START: begin
            s_next.st = CHI_H_BIT;
            s_next.bitn = 4'h0;
            s_next.sh = {CHI_SLAVE_ADDR, s_reg.stp == 3'd3};
          end
          CHI_H_BIT: begin
            s_next.bitn = s_reg.bitn + 4'h1;
            if (s_reg.bitn != 4'h8) begin
              s_next.sh = (s_reg.stp == 3'd4) ?
                {s_reg.sh[6:0], s_reg.sda_s2} : {s_reg.sh[6:0], 1'b0};
            end else if (s_reg.stp == 3'd4) begin
              s_next.rv = 1'b1;
              s_next.rdata = s_reg.sh;
              s_next.cnt = s_reg.cnt - 6'h01;
              s_next.bitn = 4'h0;
              if (s_reg.cnt == 6'h01) begin
                s_next.st = CHI_H_STOP;
              end
            end else if (s_reg.sda_s2) begin
              s_next.nack = 1'b1;
              s_next.st = CHI_H_STOP;
            end else begin
              s_next.bitn = 4'h0;
              case (s_reg.stp)
                3'd0: begin
                  s_next.stp = 3'd1;
                  s_next.sh = s_reg.reg_a;
                end
                3'd1: begin
                  if (s_reg.rd) begin
                    s_next.st = CHI_H_START;
                    s_next.stp = 3'd3;
                  end else begin
                    s_next.stp = 3'd2;
                    s_next.sh = s_reg.wdat;
                  end
                end
                3'd3: begin
                  s_next.stp = 3'd4;
                  s_next.sh = 8'h00;
                end
                default: begin
                  s_next.st = CHI_H_STOP;
                end
              endcase
            end
          end
          default: begin
            s_next.st = CHI_H_IDLE;
            s_next.done = 1'b1;
          end
        endcase
      end
    end
    // pin levels for the new quarter; data moves only once clock is low
    case (s_next.st)
      CHI_H_START: want = (s_next.q != 2'd3);
      CHI_H_STOP:  want = (s_next.q == 2'd3);
      CHI_H_BIT: begin
        if (s_next.bitn == 4'h8) begin
          want = (s_next.stp != 3'd4) || (s_next.cnt == 6'h01);
        end else begin
          want = (s_next.stp == 3'd4) || s_next.sh[7];
        end
      end
      default: want = 1'b1;
    endcase
    s_next.scl_oe_n = (s_next.st == CHI_H_IDLE) || s_next.q[1];
    if (s_next.q != 2'd0 || s_next.st == CHI_H_IDLE) begin
      s_next.sda_oe_n = want;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.scl_s1 <= 1'b1;
      s_reg.scl_s2 <= 1'b1;
      s_reg.sda_s1 <= 1'b1;
      s_reg.sda_s2 <= 1'b1;
      s_reg.scl_oe_n <= 1'b1;
      s_reg.sda_oe_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_scl_oe_n = s_reg.scl_oe_n;
  assign bus.host_sda_oe_n = s_reg.sda_oe_n;
  assign cmd_ready_o = (s_reg.st == CHI_H_IDLE);
  assign rd_valid_o = s_reg.rv;
  assign rd_data_o = s_reg.rdata;
  assign done_o = s_reg.done;
  assign nack_o = s_reg.nack;

endmodule
`default_nettype wire

// *** tb/chi_sva.sv ***
// checker for the two-wire link between the host end and the device end
`timescale 1ns/1ps
`default_nettype none
module chi_sva
  import chi_pkg::*;
#(
  parameter int STRETCH_CYC = CHI_STRETCH_CYC
) (
  input wire logic link_clk_i,
  input wire logic rst_i,
  input wire logic host_scl_o,
  input wire logic host_scl_oe_n,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic busy_o
);
  logic       scl_q;
  logic       sda_q;
  logic       wr_ok;
  logic       rd_ok;
  logic [3:0] bitn;
  logic [7:0] byten;
  logic [7:0] sh;
  int         lowcnt;
  wire        rise = scl & ~scl_q;
  wire        strt = scl & scl_q & sda_q & ~sda;
  wire        ack9 = rise & (bitn == 4'h8);

  // bit and byte position since the last start
  always_ff @(posedge link_clk_i) begin
    scl_q <= scl;
    sda_q <= sda;
    lowcnt <= dev_scl_oe_n ? 0 : lowcnt + 1;
    if (rst_i | strt) begin
      bitn <= 4'h0;
      byten <= 8'h00;
      wr_ok <= 1'b0;
      rd_ok <= 1'b0;
    end else if (ack9) begin
      bitn <= 4'h9;
      byten <= byten + {7'h00, byten != 8'hff};
      if (byten == 8'h00) begin
        wr_ok <= (sh == {CHI_SLAVE_ADDR, 1'b0});
        rd_ok <= (sh == {CHI_SLAVE_ADDR, 1'b1});
      end
    end else if (rise) begin
      bitn <= (bitn == 4'h9) ? 4'h1 : bitn + 4'h1;
      sh <= {sh[6:0], sda};
    end
  end

  default clocking cb @(posedge link_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_start;
    $fell(sda) && scl && $past(scl);
  endsequence
  sequence s_stop;
    $rose(sda) && scl && $past(scl);
  endsequence
  sequence s_addr_slot;
    ack9 && byten == 8'h00;
  endsequence
  sequence s_reg_slot;
    ack9 && byten == 8'h01 && wr_ok;
  endsequence

  a_open_drain: assert property (
    !(host_scl_o | host_sda_o | dev_scl_o | dev_sda_o))
    else $error("a pin drives high");
  a_start_busy: assert property (
    s_start |-> ##[1:6] busy_o) else $error("start not seen");
  a_stop_free: assert property (
    s_stop |-> ##[1:6] !busy_o) else $error("stop not seen");
  a_sda_scl_low: assert property (
    $changed(dev_sda_oe_n) |-> !scl) else $error("data moved, clock high");
  a_high_phase: assert property (
    $rose(scl) |-> scl [*8] ##[1:1000] (!scl || !busy_o))
    else $error("clock high phase wrong");
  a_addr_ack: assert property (
    s_addr_slot |-> dev_sda_oe_n == (sh[7:1] != CHI_SLAVE_ADDR))
    else $error("address acknowledge wrong");
  a_reg_range: assert property (
    s_reg_slot |-> dev_sda_oe_n == (sh > {2'b00, CHI_LAST_REG}))
    else $error("register address acknowledge wrong");
  a_ack_holds: assert property (
    ack9 && !dev_sda_oe_n |-> !dev_sda_oe_n until !scl)
    else $error("acknowledge dropped early");
  a_rd_release: assert property (
    ack9 && rd_ok && byten != 8'h00 |-> dev_sda_oe_n)
    else $error("transmitter held data on ninth");
  a_stretch_len: assert property (
    $rose(dev_scl_oe_n) |->
      lowcnt >= STRETCH_CYC - 1 && lowcnt <= STRETCH_CYC + 1)
    else $error("clock stretch length wrong");
endmodule
`default_nettype wire

// *** tb/charger_i2c_slave_register_port_tb.sv ***
// self-checking bench: host end and device end joined by the link
`timescale 1ns/1ps
`default_nettype none
module charger_i2c_slave_register_port_tb;
  import chi_pkg::*;
  logic       mclk_i     = 1'b0;
  logic       link_clk_i = 1'b0;
  logic       rst_i      = 1'b1;
  logic [1:0] rst_d      = 2'b11;
  logic       cmd_valid  = 1'b0;
  logic       cmd_read   = 1'b0;
  logic [7:0] cmd_reg    = 8'h00;
  logic [7:0] cmd_data   = 8'h00;
  logic [5:0] cmd_len    = 6'h01;
  logic       hw_wr      = 1'b0;
  logic [5:0] hw_addr    = 6'h00;
  logic [7:0] hw_data    = 8'h00;
  logic       cmd_ready;
  logic       rd_valid;
  logic       done;
  logic       nack;
  logic       host_wr;
  logic       busy;
  logic       seen_busy;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:0] rq[$];
  int         wr_cnt     = 0;
  int         mismatches = 0;
  int         n_compared = 0;
  int         cycles     = 0;

  always #25 mclk_i = ~mclk_i;
  // offset start keeps link edges off the master clock edges
  always begin
    #1.3;
    forever #3 link_clk_i = ~link_clk_i;
  end
  always @(posedge link_clk_i) rst_d <= {rst_d[0], rst_i};

  chi_if u_chi_if();
  chi_host #(.FAST(1)) u_chi_host (
    .mclk_i(mclk_i), .rst_i(rst_i), .bus(u_chi_if.host),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
    .cmd_read_i(cmd_read), .cmd_reg_i(cmd_reg), .cmd_data_i(cmd_data),
    .cmd_len_i(cmd_len), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
    .done_o(done), .nack_o(nack));
  chi_dev #(.STRETCH_CYC(CHI_STRETCH_CYC)) u_chi_dev (
    .link_clk_i(link_clk_i), .rst_i(rst_d[1]), .bus(u_chi_if.dev),
    .hw_wr_i(hw_wr), .hw_addr_i(hw_addr), .hw_data_i(hw_data),
    .host_wr_o(host_wr), .host_wr_addr_o(wr_addr),
    .host_wr_data_o(wr_data), .busy_o(busy));
  chi_sva #(.STRETCH_CYC(CHI_STRETCH_CYC)) u_chi_sva (
    .link_clk_i(link_clk_i), .rst_i(rst_d[1]),
    .host_scl_o(u_chi_if.host_scl_o), .host_scl_oe_n(u_chi_if.host_scl_oe_n),
    .host_sda_o(u_chi_if.host_sda_o), .host_sda_oe_n(u_chi_if.host_sda_oe_n),
    .dev_scl_o(u_chi_if.dev_scl_o), .dev_scl_oe_n(u_chi_if.dev_scl_oe_n),
    .dev_sda_o(u_chi_if.dev_sda_o), .dev_sda_oe_n(u_chi_if.dev_sda_oe_n),
    .scl(u_chi_if.scl), .sda(u_chi_if.sda), .busy_o(busy));

  always @(posedge mclk_i) if (rd_valid === 1'b1) rq.push_back(rd_data);
  always @(posedge link_clk_i) if (host_wr === 1'b1) wr_cnt++;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [7:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one host command, waits for its end of frame
  task automatic run(input logic rd, input logic [7:0] r, d,
                     input logic [5:0] n);
    int k;
    k = 0;
    seen_busy = 1'b0;
    rq.delete();
    @(negedge mclk_i);
    while (cmd_ready !== 1'b1) @(negedge mclk_i);
    @(posedge mclk_i);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_reg <= r;
    cmd_data <= d;
    cmd_len <= n;
    @(posedge mclk_i);
    cmd_valid <= 1'b0;
    while (done !== 1'b1 && k < 20000) begin
      @(negedge mclk_i);
      seen_busy |= (busy === 1'b1);
      k++;
    end
    chk("done", 8'(done), 8'h01);
  endtask

  task automatic hw_set(input logic [5:0] a, input logic [7:0] d);
    @(posedge link_clk_i);
    hw_wr <= 1'b1;
    hw_addr <= a;
    hw_data <= d;
    @(posedge link_clk_i);
    hw_wr <= 1'b0;
  endtask

  task automatic t_reset_vals();
    run(1'b1, 8'h00, 8'h00, 6'h02);
    chk("rd count", 8'(rq.size()), 8'h02);
    chk("first_register", rq[0], CHI_RST_FIRST_REGISTER);
    chk("reg01", rq[1], CHI_RST_CHG_LIMIT);
    chk("nack", 8'(nack), 8'h00);
  endtask

  task automatic t_write_read();
    int n0;
    n0 = wr_cnt;
    run(1'b0, 8'h05, 8'ha5, 6'h01);
    chk("busy seen", 8'(seen_busy), 8'h01);
    chk("busy end", 8'(busy), 8'h00);
    chk("wr nack", 8'(nack), 8'h00);
    chk("wr pulses", 8'(wr_cnt - n0), 8'h01);
    chk("wr addr", {2'b00, wr_addr}, 8'h05);
    chk("wr data", wr_data, 8'ha5);
    run(1'b1, 8'h05, 8'h00, 6'h01);
    chk("rd back", rq[0], 8'ha5);
  endtask

  task automatic t_burst_end();
    hw_set(6'h24, 8'h3c);
    run(1'b1, 8'h24, 8'h00, 6'h03);
    chk("reg24", rq[0], 8'h3c);
    chk("last_register", rq[1], 8'h00);
    chk("past end", rq[2], CHI_FILL_BYTE);
  endtask

  task automatic t_bad_reg();
    int n0;
    n0 = wr_cnt;
    run(1'b0, 8'h26, 8'h11, 6'h01);
    chk("bad wr nack", 8'(nack), 8'h01);
    chk("bad wr none", 8'(wr_cnt - n0), 8'h00);
    run(1'b1, 8'h80, 8'h00, 6'h01);
    chk("bad rd nack", 8'(nack), 8'h01);
    run(1'b1, 8'h01, 8'h00, 6'h01);
    chk("idle again", rq[0], CHI_RST_CHG_LIMIT);
    chk("good nack", 8'(nack), 8'h00);
  endtask

  task automatic t_flag();
    int n0;
    n0 = wr_cnt;
    run(1'b0, 8'h0a, 8'h77, 6'h01);
    chk("ro none", 8'(wr_cnt - n0), 8'h00);
    hw_set(6'h0f, 8'h81);
    hw_set(6'h0f, 8'h02);
    run(1'b1, 8'h0f, 8'h00, 6'h01);
    chk("flag set", rq[0], 8'h83);
    run(1'b1, 8'h0f, 8'h00, 6'h01);
    chk("flag clear", rq[0], 8'h00);
  endtask

  initial begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    t_reset_vals();
    t_write_read();
    t_burst_end();
    t_bad_reg();
    t_flag();
    report_and_stop();
  end
endmodule
`default_nettype wire
